// *** shared/spm_pkg.sv ***
// package: register map, field positions and pin groupings for the boot port pin mux
package spm_pkg;

  // data memory addresses of the two control registers
  localparam logic [13:0] MODE_CTRL_ADDR   = 14'h2015;
  localparam logic [13:0] SYS_CTRL_ADDR    = 14'h3FFF;
  // field positions
  localparam int          MODE_RXSEL_BIT   = 4;
  localparam int          MODE_UART_BIT    = 5;
  localparam int          SYS_ALTFLAG_BIT  = 10;
  localparam int          MODE_W           = 9;
  localparam int          SYS_W            = 16;
  // reset values
  localparam logic [8:0]  MODE_RESET       = 9'h000;
  localparam logic [15:0] SYS_RESET        = 16'h0000;
  localparam logic        FLAG_RESET       = 1'b0;
  // toggles after a set that form one reset request
  localparam logic [1:0]  TOGGLES_NEEDED   = 2'h2;
  // program start after a good serial download
  localparam logic [13:0] USER_START_ADDR  = 14'h0030;
  // length of the peripheral reset pulse, in clocks
  localparam logic [3:0]  PRESET_CYCLES    = 4'h4;

  // pins of the boot serial port as seen from outside
  typedef struct packed {
    logic receive_pin_primary;
    logic receive_pin_secondary;
    logic receive_frame_sync;
    logic transmit_frame_sync;
    logic serial_clock_pin;
  } spm_pins_in_t;

  // signals towards the serial port engine and core
  typedef struct packed {
    logic port_receive_input;
    logic port_frame_sync;
    logic port_tfs;
    logic port_sclk;
    logic flag_input_pin;
    logic ext_interrupt_zero;
    logic ext_interrupt_one;
  } spm_core_in_t;

  // core register access port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [13:0] addr;
    logic [15:0] wdata;
  } spm_dm_req_t;

endpackage

// *** design/spm_sync.sv ***
// two-stage synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module spm_sync #(
  parameter int W = 5
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** design/spm_flag_seq.sv ***
// detects set, toggle, toggle on a software flag and issues one request pulse
`timescale 1ns/10ps
module spm_flag_seq (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic flag,
  output logic      fire
);
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SET  = 2'b01,
    SEQ_TG1  = 2'b10
  } spm_seq_t;

  spm_seq_t seq_r;
  spm_seq_t seq_nxt;
  logic     flag_d_r;
  logic     fire_nxt;
  wire      rise = flag & ~flag_d_r;
  wire      edge_any = flag ^ flag_d_r;

  // set, then two inversions; a fresh rise from idle restarts the count
  always_comb begin
    seq_nxt  = seq_r;
    fire_nxt = 1'b0;
    case (seq_r)
      SEQ_IDLE: begin
        if (rise) seq_nxt = SEQ_SET;
      end
      SEQ_SET: begin
        if (edge_any) seq_nxt = SEQ_TG1;
      end
      SEQ_TG1: begin
        if (edge_any) begin
          seq_nxt  = SEQ_IDLE;
          fire_nxt = 1'b1;
        end
      end
      default: seq_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seq_r    <= SEQ_IDLE;
      flag_d_r <= 1'b0;
      fire     <= 1'b0;
    end else begin
      seq_r    <= seq_nxt;
      flag_d_r <= flag;
      fire     <= fire_nxt;
    end
  end
endmodule

// *** design/spm_boot_mux.sv ***
// boot serial port pin routing, uart tie, serial rom reset and peripheral reset
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module spm_boot_mux (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire spm_pkg::spm_dm_req_t dm_req,
  output logic              [15:0] dm_rdata,
  output logic                     dm_hit,
  input  wire spm_pkg::spm_pins_in_t pins_in,
  input  wire logic                software_flag_one,
  input  wire logic                software_flag_two,
  input  wire logic                flag_output_pin,
  input  wire logic                port_transmit_data,
  input  wire logic                port_rfs_out,
  input  wire logic                port_rfs_oe,
  output spm_pkg::spm_core_in_t    core_in,
  output logic                     serial_rom_reset_pin_o,
  output logic                     serial_rom_reset_pin_oe,
  output logic                     transmit_data_pin,
  output logic                     periph_reset,
  output logic [13:0]              user_start_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [spm_pkg::MODE_W-1:0] mode_ctrl_r;
  logic [spm_pkg::MODE_W-1:0] mode_ctrl_nxt;
  logic [spm_pkg::SYS_W-1:0]  sys_ctrl_r;
  logic [spm_pkg::SYS_W-1:0]  sys_ctrl_nxt;
  logic [3:0]                 preset_cnt_r;
  logic [3:0]                 preset_cnt_nxt;
  logic [15:0]                rdata_nxt;
  logic                       preset_fire;
  spm_pkg::spm_pins_in_t      pins_s;

  // every pin passes two flops before routing reads it
  spm_sync #(
    .W ($bits(spm_pkg::spm_pins_in_t))
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (pins_in),
    .q       (pins_s)
  );

  // flag two sequence detector
  spm_flag_seq u_preset (
    .ref_clk (ref_clk),
    .rst     (rst),
    .flag    (software_flag_two),
    .fire    (preset_fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire mode_sel = dm_req.addr == spm_pkg::MODE_CTRL_ADDR;
  wire sys_sel  = dm_req.addr == spm_pkg::SYS_CTRL_ADDR;
  wire preset_active = preset_cnt_r != 4'h0;

  // writes land next edge; a peripheral reset clears mode control only
  assign mode_ctrl_nxt = preset_active ? spm_pkg::MODE_RESET :
                         (dm_req.wr && mode_sel) ? dm_req.wdata[spm_pkg::MODE_W-1:0]
                                                 : mode_ctrl_r;
  assign sys_ctrl_nxt  = (dm_req.wr && sys_sel) ? dm_req.wdata : sys_ctrl_r;
  assign rdata_nxt     = mode_sel ? {7'h00, mode_ctrl_r} :
                         sys_sel  ? sys_ctrl_r : 16'h0000;

  // peripheral reset pulse stretch, reloaded with PRESET_CYCLES on each flag two request
  assign preset_cnt_nxt = preset_fire   ? spm_pkg::PRESET_CYCLES :
                          preset_active ? preset_cnt_r - 4'h1 : 4'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_ctrl_r  <= spm_pkg::MODE_RESET;
      sys_ctrl_r   <= spm_pkg::SYS_RESET;
      preset_cnt_r <= 4'h0;
      dm_rdata     <= 16'h0000;
      dm_hit       <= 1'b0;
    end else begin
      mode_ctrl_r  <= mode_ctrl_nxt;
      sys_ctrl_r   <= sys_ctrl_nxt;
      preset_cnt_r <= preset_cnt_nxt;
      dm_rdata     <= rdata_nxt;
      dm_hit       <= dm_req.rd && (mode_sel || sys_sel);
    end
  end

  assign periph_reset = preset_active;

  ////////////////////////////////////////////////////////////////////////////
  // pin routing, purely from the current control bits
  wire rx_sel   = mode_ctrl_r[spm_pkg::MODE_RXSEL_BIT];
  wire uart_en  = mode_ctrl_r[spm_pkg::MODE_UART_BIT];
  wire alt_flag = sys_ctrl_r[spm_pkg::SYS_ALTFLAG_BIT];
  wire rx_pin   = rx_sel ? pins_s.receive_pin_secondary
                         : pins_s.receive_pin_primary;

  // in uart mode outside the alternate config the frame sync sees the data line, so stream start is found
  assign core_in.port_receive_input = alt_flag ? 1'b0 : rx_pin;
  assign core_in.port_frame_sync    = alt_flag ? 1'b0 :
                                      uart_en ? rx_pin : pins_s.receive_frame_sync;
  assign core_in.port_tfs           = alt_flag ? 1'b0 : pins_s.transmit_frame_sync;
  assign core_in.port_sclk          = pins_s.serial_clock_pin;
  assign core_in.flag_input_pin     = alt_flag ? rx_pin : 1'b0;
  assign core_in.ext_interrupt_zero = alt_flag ? pins_s.receive_frame_sync : 1'b1;
  assign core_in.ext_interrupt_one  = alt_flag ? pins_s.transmit_frame_sync : 1'b1;

  // transmit pin carries flag out in alternate config
  assign transmit_data_pin = alt_flag ? flag_output_pin : port_transmit_data;

  // shared frame sync / rom reset pin; flag one owns it in uart mode
  assign serial_rom_reset_pin_o  = uart_en ? software_flag_one : port_rfs_out;
  assign serial_rom_reset_pin_oe = uart_en ? 1'b1 : (port_rfs_oe & ~alt_flag);

  // fixed entry point used by the boot monitor after a good download
  assign user_start_addr = spm_pkg::USER_START_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence flag2_set_s;
    $rose(software_flag_two);
  endsequence

  rx_route_a: assert property (@(posedge ref_clk) disable iff (rst)
    !alt_flag |-> core_in.port_receive_input ==
      (mode_ctrl_r[4] ? pins_s.receive_pin_secondary : pins_s.receive_pin_primary))
    else $error("receive pin routing wrong");

  uart_tie_a: assert property (@(posedge ref_clk) disable iff (rst)
    (uart_en && !alt_flag) |-> core_in.port_frame_sync == core_in.port_receive_input)
    else $error("uart tie broken");

  rom_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    uart_en |-> (serial_rom_reset_pin_oe && serial_rom_reset_pin_o == software_flag_one))
    else $error("rom reset pin not from flag one");

  alt_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    alt_flag |-> (transmit_data_pin == flag_output_pin && core_in.flag_input_pin == rx_pin))
    else $error("alternate flag pins wrong");

  alt_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    alt_flag |-> (core_in.ext_interrupt_zero == pins_s.receive_frame_sync &&
                  core_in.ext_interrupt_one == pins_s.transmit_frame_sync))
    else $error("interrupt routing wrong");

  sclk_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    core_in.port_sclk == pins_s.serial_clock_pin)
    else $error("serial clock lost");

  preset_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(preset_fire) |=> periph_reset [*4] ##1 !periph_reset)
    else $error("peripheral reset length wrong");

  preset_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
    periph_reset |=> mode_ctrl_r == 9'h000)
    else $error("mode control not cleared");

  mode_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (dm_req.wr && mode_sel && !preset_active) |=> mode_ctrl_r == $past(dm_req.wdata[8:0]))
    else $error("mode write not taken");

  flag2_seq_a: assert property (@(posedge ref_clk) disable iff (rst)
    flag2_set_s ##1 (software_flag_two [*2]) ##1 !software_flag_two ##1
      (!software_flag_two [*2]) ##1 software_flag_two |-> ##[1:2] preset_fire)
    else $error("flag two sequence missed");

  start_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    user_start_addr == 14'h0030)
    else $error("start address wrong");

endmodule

// *** verif/spm_rom_model.sv ***
// serial rom model: streams one word after a low pulse on its reset pin
`timescale 1ns/10ps
module spm_rom_model #(
  parameter logic [7:0] WORD = 8'hA5
) (
  input  wire logic armed,
  input  wire logic rom_rst,
  output logic      rom_data,
  output logic      rom_sclk
);
  // clock stands still outside the frame; line shows inverse of last bit after it
  initial begin
    rom_data = 1'b0;
    rom_sclk = 1'b0;
    forever begin
      @(negedge rom_rst iff armed);
      @(posedge rom_rst);
      for (int i = 7; i >= 0; i--) begin
        rom_data = WORD[i];
        #200 rom_sclk = 1'b1;
        #200 rom_sclk = 1'b0;
      end
      rom_data = ~WORD[0];
    end
  end
endmodule

// *** verif/testbench.sv ***
// bench: reset, register, routing, rom boot and peripheral reset checks
`timescale 1ns/10ps
module testbench;
  logic                       ref_clk = 1'b0;
  logic                       rst = 1'b1;
  spm_pkg::spm_dm_req_t       req = '0;
  logic                       pri, sck, sec, rfs, tfs, fl1, fl2, fo, ptd, rfso, rfsoe, armed;
  logic                [15:0] rdata;
  logic                       hit, rom_o, rom_oe, tdp, prst, rom_data, rom_sclk;
  logic                [13:0] usa;
  spm_pkg::spm_core_in_t      core_in;
  logic                 [8:0] mode_m = 9'h000;
  logic                [15:0] sys_m = 16'h0000;
  int unsigned                seed = 77001;
  int unsigned                r;
  int                         n_checks = 0;
  int                         n_mismatch = 0;
  int                         n_fall = 0;
  int                         k;
  wire                        rom_rst = rom_o & rom_oe;
  // rom owns primary data and clock while armed; the bench drives them otherwise
  wire spm_pkg::spm_pins_in_t pins = {armed ? rom_data : pri, sec, rfs, tfs,
                                      armed ? rom_sclk : sck};

  spm_boot_mux DUT (.ref_clk(ref_clk), .rst(rst), .dm_req(req), .dm_rdata(rdata),
    .dm_hit(hit), .pins_in(pins), .software_flag_one(fl1), .software_flag_two(fl2),
    .flag_output_pin(fo), .port_transmit_data(ptd), .port_rfs_out(rfso),
    .port_rfs_oe(rfsoe), .core_in(core_in), .serial_rom_reset_pin_o(rom_o),
    .serial_rom_reset_pin_oe(rom_oe), .transmit_data_pin(tdp), .periph_reset(prst),
    .user_start_addr(usa));
  spm_rom_model ROM (.armed(armed), .rom_rst(rom_rst), .rom_data(rom_data),
    .rom_sclk(rom_sclk));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // rom pulses counted as falls of the shared pin
  always @(negedge rom_rst) n_fall++;

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected engine-side inputs from the model registers and pins
  function automatic logic [6:0] exp_core();
    logic s;
    s = mode_m[4] ? pins.receive_pin_secondary : pins.receive_pin_primary;
    if (sys_m[10]) return {3'h0, pins.serial_clock_pin, s, pins.receive_frame_sync,
      pins.transmit_frame_sync};
    return {s, mode_m[5] ? s : pins.receive_frame_sync, pins.transmit_frame_sync,
      pins.serial_clock_pin, 3'h3};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] e, input string what);
    n_checks++;
    if (seen !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic bus_wr(input logic [13:0] a, input logic [15:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
    if (a == spm_pkg::MODE_CTRL_ADDR) mode_m = d[8:0];
    if (a == spm_pkg::SYS_CTRL_ADDR) sys_m = d;
    @(posedge ref_clk);
  endtask
  task automatic bus_rd(input logic [13:0] a, input logic [15:0] e, input logic h);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    req <= '0;
    #1;
    chk(rdata, e, "rdata");
    chk(16'(hit), 16'(h), "hit");
    @(posedge ref_clk);
  endtask
  // pins need two synchroniser cycles before the routing shows them
  task automatic route_chk();
    repeat (3) @(posedge ref_clk);
    #1;
    chk(16'(core_in), 16'(exp_core()), "core_in");
    // engine frame sync may not drive the pin while it serves as interrupt input
    chk(16'({rom_o, rom_oe}),
        16'(mode_m[5] ? {fl1, 1'b1} : {rfso, rfsoe & ~sys_m[10]}), "rom");
    chk(16'(tdp), 16'(sys_m[10] ? fo : ptd), "tx_pin");
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {pri, sck, sec, rfs, tfs, fl1, fl2, fo, ptd, rfso, rfsoe, armed} = '0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus_rd(spm_pkg::MODE_CTRL_ADDR, 16'h0000, 1'b1);
    bus_rd(spm_pkg::SYS_CTRL_ADDR, 16'h0000, 1'b1);
    bus_rd(14'h2014, 16'h0000, 1'b0);
    route_chk();
    $display("test reset done");
    // random selections; uart kept off under the alternate config
    for (int i = 0; i < 40; i++) begin
      r = xs();
      if (r[26]) r[5] = 1'b0;
      bus_wr(spm_pkg::MODE_CTRL_ADDR, r[15:0]);
      bus_wr(spm_pkg::SYS_CTRL_ADDR, r[31:16]);
      r = xs();
      {pri, sck, sec, rfs, tfs, fl1, fo, ptd, rfso, rfsoe} <= r[9:0];
      route_chk();
      bus_rd(spm_pkg::MODE_CTRL_ADDR, {7'h00, mode_m}, 1'b1);
    end
    $display("test routing done");
    fl1 <= 1'b0;
    bus_wr(spm_pkg::SYS_CTRL_ADDR, 16'h0000);
    bus_wr(spm_pkg::MODE_CTRL_ADDR, 16'h0020);
    n_fall = 0;
    armed <= 1'b1;
    @(posedge ref_clk);
    // set, toggle, toggle
    fl1 <= 1'b1;
    @(posedge ref_clk);
    fl1 <= 1'b0;
    @(posedge ref_clk);
    fl1 <= 1'b1;
    // look just after the edge so the synchronised value has settled
    for (k = 0; k < 200 && core_in.port_frame_sync !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 200) begin
      n_mismatch++;
      tally_and_finish();
    end
    chk(16'(core_in.port_receive_input), 16'h0001, "rx_in");
    chk(16'(n_fall), 16'h0001, "rom_pulses");
    repeat (80) @(posedge ref_clk);
    armed <= 1'b0;
    bus_wr(spm_pkg::MODE_CTRL_ADDR, 16'h0030);
    route_chk();
    // failed boot: the host shifts a header byte in on the secondary pin
    r = xs();
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk);
      sec <= r[i];
      repeat (3) @(posedge ref_clk);
      #1;
      chk(16'(core_in[6:5]), 16'({2{r[i]}}), "header");
    end
    bus_wr(spm_pkg::MODE_CTRL_ADDR, 16'h0010);
    route_chk();
    chk(16'(usa), 16'h0030, "start");
    $display("test boot done");
    bus_wr(spm_pkg::SYS_CTRL_ADDR, 16'h0400);
    fl2 <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fl2 <= 1'b0;
    repeat (3) @(posedge ref_clk);
    fl2 <= 1'b1;
    k = 0;
    repeat (20) begin
      @(posedge ref_clk);
      #1;
      if (prst === 1'b1) k++;
    end
    chk(16'(k), 16'(spm_pkg::PRESET_CYCLES), "preset_len");
    mode_m = spm_pkg::MODE_RESET;
    @(posedge ref_clk);
    bus_rd(spm_pkg::MODE_CTRL_ADDR, 16'h0000, 1'b1);
    bus_rd(spm_pkg::SYS_CTRL_ADDR, sys_m, 1'b1);
    route_chk();
    $display("test preset done");
    // hardware reset in mid-run must clear both control registers again
    fl2 <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    mode_m = spm_pkg::MODE_RESET;
    sys_m  = spm_pkg::SYS_RESET;
    @(posedge ref_clk);
    bus_rd(spm_pkg::MODE_CTRL_ADDR, 16'h0000, 1'b1);
    bus_rd(spm_pkg::SYS_CTRL_ADDR, 16'h0000, 1'b1);
    route_chk();
    $display("test hw reset done");
    tally_and_finish();
  end
endmodule
